// ===== hw/ddp_core.sv
// Purpose: Device-side pin behaviour of an x4/x8 DDR3 memory, plus read-data FIFO
// Assumes: All pins except the asynchronous reset pin are sampled by sys_clk through two flip-flops; link clock is slow
// Notes: Data storage itself lives outside; write beats leave on a strobe port
`timescale 1ns/10ps

// Read data buffer, flip-flop storage with registered flags
module ddp_fifo #(
  parameter int W = 8, // Word width
  parameter int DEPTH = 16 // Number of words
) (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic in_valid, // Filler offers a word
  output logic in_ready, // Room for a word
  input wire logic [W-1:0] in_data, // Word in
  output logic out_valid, // A word is waiting
  input wire logic out_ready, // Drainer takes the word
  output logic [W-1:0] out_data // Word at the head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [W-1:0] mem [DEPTH]; // Storage
  logic [AW-1:0] wr_ptr; // Next write slot
  logic [AW-1:0] rd_ptr; // Head slot
  logic [AW:0] count; // Words held
  logic push; // Accepted write
  logic pop; // Accepted read
  logic [AW:0] next_count; // Count after this cycle

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers wrap explicitly so DEPTH need not be a power of two
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
    end
  end

  // Flags are registered from the next count, so they are honest each cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
      out_valid <= (next_count != '0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module ddp_core import ddp_pkg::*; #(
  parameter int DQ_W = 8, // Data width, 4 or 8
  parameter int FIFO_DEPTH = 16 // Read buffer depth
) (
  input wire logic sys_clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic ck, // Link clock (true phase)
  input wire logic cke, // Clock enable
  input wire logic cs_n, // Chip select, active low
  input wire logic ras_n, // Row strobe, active low
  input wire logic cas_n, // Column strobe, active low
  input wire logic we_n, // Write enable, active low
  input wire logic [2:0] ba, // Bank address
  input wire logic [13:0] addr, // Address / op-code
  input wire logic odt, // Termination control
  input wire logic mem_rst_n, // Device reset pin, active low
  input wire logic dm, // Write data mask
  input wire logic [DQ_W-1:0] dq_in, // Data pins, input side
  input wire logic dqs_in, // Strobe pin, input side
  output logic [DQ_W-1:0] dq_out, // Data pins, output side
  output logic dq_oe_n, // Data drive enable, low drives
  output logic dqs_out, // Strobe pin, output side
  output logic dqs_oe_n, // Strobe drive enable, low drives
  output logic term_on, // Termination applied to data, strobe, mask
  output logic tdqs_term, // Termination strobe pins terminating
  output logic dm_enabled, // Data mask function active
  output logic [1:0] pwr_state, // Power state code
  output logic [7:0] bank_open, // Open row per bank
  output logic cmd_valid, // Decoded command pulse
  output logic [2:0] cmd_code, // Decoded command
  output logic [2:0] cmd_bank, // Target bank of the command
  output logic wr_valid, // Stored write beat pulse
  output logic [DQ_W-1:0] wr_data, // Stored write beat
  input wire logic rd_in_valid, // Read data word offered
  output logic rd_in_ready, // Read buffer has room
  input wire logic [DQ_W-1:0] rd_in_data // Read data word
);
  localparam int NI = 26 + DQ_W; // Width of the sampled pin vector
  localparam logic [3:0] BURST = 4'(DDP_BURST_LEN);
  localparam logic [3:0] BEAT = 4'(DDP_BEAT_CYC);

  logic [NI-1:0] pin_s1; // First sampling stage
  logic [NI-1:0] pin_s2; // Second sampling stage
  logic [1:0] rst_sync; // Reset pin synchroniser
  logic rst; // Combined reset
  logic ck_d; // Previous link clock level
  logic dqs_d; // Previous strobe level
  logic ck_s, cke_s, cs_s, odt_s, dm_s, dqs_s; // Sampled pins
  logic [2:0] cmd_s; // Sampled command strobes
  logic [2:0] ba_s; // Sampled bank address
  logic [13:0] addr_s; // Sampled address
  logic [DQ_W-1:0] dq_s; // Sampled data
  logic ck_rise; // Rising link clock seen
  logic dqs_edge; // Any strobe edge seen
  logic cmd_ok; // Command accepted this cycle
  ddp_state_t st; // Power state
  logic mr_odt_en; // Termination enabled by mode load
  logic mr_tdqs_en; // Termination strobe enabled
  logic [3:0] wr_left; // Write beats still due
  logic [3:0] rd_left; // Read beats still due
  logic [3:0] beat_tmr; // Cycles left in the current read beat
  logic f_valid; // Read word waiting
  logic f_pop; // Take a read word
  logic [DQ_W-1:0] f_data; // Read word at head

  // Async assertion clears at once; release is resynchronised to sys_clk
  always_ff @(posedge sys_clk or negedge mem_rst_n) begin
    if (!mem_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst = sys_rst | ~rst_sync[1];

  // Two-stage sampling of every pin except the reset pin; second stage alone is read
  always_ff @(posedge sys_clk) begin
    pin_s1 <= {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt, dm, dqs_in, dq_in};
    pin_s2 <= pin_s1;
  end
  assign {ck_s, cke_s, cs_s, cmd_s, ba_s, addr_s, odt_s, dm_s, dqs_s, dq_s} = pin_s2;

  // Edge history taken from the second stage only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ck_d <= 1'b0;
      dqs_d <= 1'b0;
    end else begin
      ck_d <= ck_s;
      dqs_d <= dqs_s;
    end
  end
  assign ck_rise = ck_s & ~ck_d;
  assign dqs_edge = dqs_s ^ dqs_d;

  // Decoder runs only while awake and selected; power-down masks it
  assign cmd_ok = ck_rise & (st == DDP_ST_ACT) & cke_s & ~cs_s;

  // Power state machine
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= DDP_ST_ACT;
    end else begin
      unique case (st)
        DDP_ST_ACT: begin
          if (ck_rise & ~cke_s) begin
            if (~cs_s & (cmd_s == DDP_CMD_REF) & (bank_open == 8'h00)) begin
              st <= DDP_ST_SREF;
            end else if (bank_open != 8'h00) begin
              st <= DDP_ST_APD;
            end else begin
              st <= DDP_ST_PPD;
            end
          end
        end
        DDP_ST_APD, DDP_ST_PPD: begin
          if (ck_rise & cke_s) begin
            st <= DDP_ST_ACT;
          end
        end
        DDP_ST_SREF: begin
          // Exit needs no link clock edge: the enable level alone wakes us
          if (cke_s) begin
            st <= DDP_ST_ACT;
          end
        end
      endcase
    end
  end
  assign pwr_state = st;

  // Command decode, bank tracking and mode load
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_valid <= 1'b0;
      cmd_code <= DDP_CMD_NOP;
      cmd_bank <= 3'h0;
      bank_open <= 8'h00;
      mr_odt_en <= DDP_RST_ODT_EN;
      mr_tdqs_en <= DDP_RST_TDQS_EN;
    end else begin
      cmd_valid <= cmd_ok & (cmd_s != DDP_CMD_NOP);
      // A no-op leaves the last decoded command on show, so code moves only with a pulse
      if (cmd_ok & (cmd_s != DDP_CMD_NOP)) begin
        cmd_code <= cmd_s;
        cmd_bank <= ba_s;
        unique case (cmd_s)
          DDP_CMD_ACT: begin
            bank_open[ba_s] <= 1'b1;
          end
          DDP_CMD_PRE: begin
            if (addr_s[DDP_AP_BIT]) begin
              bank_open <= 8'h00;
            end else begin
              bank_open[ba_s] <= 1'b0;
            end
          end
          DDP_CMD_RD, DDP_CMD_WR: begin
            // Auto-precharge closes the row at once; row timing is outside
            if (addr_s[DDP_AP_BIT]) begin
              bank_open[ba_s] <= 1'b0;
            end
          end
          DDP_CMD_MRS: begin
            if (ba_s == DDP_MR1_SEL) begin
              mr_odt_en <= addr_s[DDP_MR1_RTT0] | addr_s[DDP_MR1_RTT1] | addr_s[DDP_MR1_RTT2];
              mr_tdqs_en <= (DQ_W == 8) & addr_s[DDP_MR1_TDQS];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Termination follows the control at each link clock rise while enabled by mode load and outside self refresh
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      term_on <= 1'b0;
      tdqs_term <= 1'b0;
    end else if (~mr_odt_en | (st == DDP_ST_SREF)) begin
      term_on <= 1'b0;
      tdqs_term <= 1'b0;
    end else if (ck_rise) begin
      term_on <= odt_s;
      tdqs_term <= odt_s & mr_tdqs_en;
    end else begin
      // Drop strobe termination as soon as the mask function comes back
      tdqs_term <= tdqs_term & mr_tdqs_en;
    end
  end

  // Mask function is lost while the x8 termination strobe is enabled
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dm_enabled <= 1'b1;
    end else begin
      dm_enabled <= ~mr_tdqs_en;
    end
  end

  // Write beats: the controller centres its strobe, so each edge marks a stable beat
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_left <= 4'h0;
      wr_valid <= 1'b0;
      wr_data <= '0;
    end else begin
      wr_valid <= 1'b0;
      if (cmd_ok & (cmd_s == DDP_CMD_WR)) begin
        wr_left <= BURST;
      end else if ((st == DDP_ST_ACT) & dqs_edge & (wr_left != 4'h0)) begin
        wr_left <= wr_left - 1'b1;
        if (~(dm_s & dm_enabled)) begin
          wr_valid <= 1'b1;
          wr_data <= dq_s;
        end
      end
    end
  end

  // Read beats leave the buffer; an empty buffer stalls the burst
  assign f_pop = (rd_left != 4'h0) & (beat_tmr == 4'h0) & f_valid;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_left <= 4'h0;
      beat_tmr <= 4'h0;
      dq_out <= '0;
      dq_oe_n <= 1'b1;
      dqs_out <= 1'b0;
      dqs_oe_n <= 1'b1;
    end else begin
      if (beat_tmr != 4'h0) begin
        beat_tmr <= beat_tmr - 1'b1;
      end
      if (cmd_ok & (cmd_s == DDP_CMD_RD) & (rd_left == 4'h0)) begin
        rd_left <= BURST;
      end else if (f_pop) begin
        // Data and strobe change together, so strobe edges align with beats
        rd_left <= rd_left - 1'b1;
        beat_tmr <= BEAT - 1'b1;
        dq_out <= f_data;
        dqs_out <= ~dqs_out;
        dq_oe_n <= 1'b0;
        dqs_oe_n <= 1'b0;
      end else if ((rd_left == 4'h0) & (beat_tmr == 4'h0)) begin
        dq_oe_n <= 1'b1;
        dqs_oe_n <= 1'b1;
        dqs_out <= 1'b0;
      end
    end
  end

  ddp_fifo #(
    .W(DQ_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rd_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(rd_in_valid),
    .in_ready(rd_in_ready),
    .in_data(rd_in_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );
endmodule

// ===== hw/ddp_pkg.sv
// Purpose: Shared constants and types for the DDR3 pin-behaviour device block
// Assumes: System clock at 200 MHz; memory link clock sampled, not used as a clock
// Notes: Command codes are the {row, column, write} strobe levels with select low
package ddp_pkg;
  // Power / clock-gating state of the device
  typedef enum logic [1:0] {
    DDP_ST_ACT  = 2'b00, // Clocks and receivers enabled
    DDP_ST_APD  = 2'b01, // Active power-down (a row is open)
    DDP_ST_PPD  = 2'b10, // Precharge power-down (all banks idle)
    DDP_ST_SREF = 2'b11  // Self refresh
  } ddp_state_t;

  // Command codes on {ras_n, cas_n, we_n}
  localparam logic [2:0] DDP_CMD_MRS = 3'h0; // Mode register load
  localparam logic [2:0] DDP_CMD_REF = 3'h1; // Refresh (self refresh with clock enable low)
  localparam logic [2:0] DDP_CMD_PRE = 3'h2; // Precharge
  localparam logic [2:0] DDP_CMD_ACT = 3'h3; // Activate
  localparam logic [2:0] DDP_CMD_WR = 3'h4; // Write
  localparam logic [2:0] DDP_CMD_RD = 3'h5; // Read
  localparam logic [2:0] DDP_CMD_NOP = 3'h7; // No operation

  // Mode register 1 select and field positions
  localparam logic [2:0] DDP_MR1_SEL = 3'h1; // Bank address selecting mode register 1
  localparam int DDP_MR1_RTT0 = 2; // Termination value bit 0
  localparam int DDP_MR1_RTT1 = 6; // Termination value bit 1
  localparam int DDP_MR1_RTT2 = 9; // Termination value bit 2
  localparam int DDP_MR1_TDQS = 11; // Termination strobe enable
  localparam int DDP_AP_BIT = 10; // Auto-precharge / all-banks address bit

  // Burst and timing
  localparam int DDP_BURST_LEN = 8; // Data beats per access
  localparam int DDP_SYS_CLK_NS = 5; // System clock period
  localparam int DDP_BEAT_NS = 32; // Read beat time, half of a link clock period
  localparam int DDP_BEAT_CYC = (DDP_BEAT_NS / DDP_SYS_CLK_NS < 1) ? 1 : DDP_BEAT_NS / DDP_SYS_CLK_NS;

  // Reset values
  localparam logic DDP_RST_ODT_EN = 1'b1; // Termination control honoured after reset
  localparam logic DDP_RST_TDQS_EN = 1'b0; // Termination strobe off after reset
endpackage

// ===== testbench/ddp_core_assertions.sv
// Purpose: Port-level checks for ddp_core
// Assumes: Either reset disables every check
// Notes: Pins pass a two-flop sync, so pulses lag the link clock
`timescale 1ns/10ps
module ddp_core_checker import ddp_pkg::*; #(
  parameter int DQ_W = 8 // Data width
) (
  input wire logic sys_clk, // Clock
  input wire logic sys_rst, // Sync reset
  input wire logic mem_rst_n, // Pin reset
  input wire logic dq_oe_n, // Data drive
  input wire logic dqs_oe_n, // Strobe drive
  input wire logic [DQ_W-1:0] dq_out, // Read data
  input wire logic dqs_out, // Read strobe
  input wire logic term_on, // Termination
  input wire logic tdqs_term, // Term strobe
  input wire logic dm_enabled, // Mask on
  input wire logic [1:0] pwr_state, // Power state
  input wire logic [7:0] bank_open, // Open banks
  input wire logic cmd_valid, // Command pulse
  input wire logic [2:0] cmd_code, // Command
  input wire logic [2:0] cmd_bank // Bank
);
  // One domain, so clock and disable are shared
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !mem_rst_n);
  AST_OE_PAIR: assert property (dq_oe_n == dqs_oe_n)
    else $error("data and strobe drive differ");
  AST_DQS_EDGE: assert property (!dq_oe_n && $changed(dq_out) |-> $changed(dqs_out))
    else $error("read data moved without strobe");
  AST_PD_NO_CMD: assert property (pwr_state != 2'b00 |-> !cmd_valid)
    else $error("command decoded while powered down");
  // One settled cycle first, in case termination is registered from the state
  AST_SR_TERM: assert property (pwr_state == 2'b11 && $past(pwr_state) == 2'b11 |-> !term_on)
    else $error("termination on in self refresh");
  AST_TDQS_DM: assert property (tdqs_term |-> !dm_enabled)
    else $error("mask active with termination strobe");
  AST_CODE_HOLD: assert property (!cmd_valid |-> $stable(cmd_code) && $stable(cmd_bank))
    else $error("command code moved without pulse");
  AST_NOP_HIDDEN: assert property (cmd_valid |-> cmd_code != DDP_CMD_NOP)
    else $error("no-op reported");
  AST_ACT_OPEN: assert property (cmd_valid && cmd_code == DDP_CMD_ACT |-> bank_open[cmd_bank])
    else $error("activated bank not open");
  AST_APD_OPEN: assert property (pwr_state == 2'b01 |-> bank_open != 8'h00)
    else $error("active power-down with banks idle");
  AST_PPD_IDLE: assert property (pwr_state[1] |-> bank_open == 8'h00)
    else $error("idle power state with open bank");
  cover property (cmd_valid && cmd_code == DDP_CMD_RD);
  cover property (pwr_state == 2'b11);
  cover property ($fell(dq_oe_n));
endmodule

bind ddp_core ddp_core_checker #(.DQ_W(DQ_W)) chk_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .mem_rst_n(mem_rst_n), .dq_oe_n(dq_oe_n), .dqs_oe_n(dqs_oe_n), .dq_out(dq_out), .dqs_out(dqs_out),
  .term_on(term_on), .tdqs_term(tdqs_term), .dm_enabled(dm_enabled), .pwr_state(pwr_state),
  .bank_open(bank_open), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank));

// ===== testbench/ddp_ctrl_model.sv
// Purpose: Memory controller model driving the link
// Assumes: Link clock runs free at 64 ns
// Notes: Released address, bank and data lines show the inverse of their last value
`timescale 1ns/10ps
module ddp_ctrl_model import ddp_pkg::*; (
  input wire logic sys_clk, // Pacing clock
  output logic ck, // Link clock
  output logic cke, // Clock enable
  output logic cs_n, // Select
  output logic ras_n, // Row strobe
  output logic cas_n, // Column strobe
  output logic we_n, // Write strobe
  output logic [2:0] ba, // Bank
  output logic [13:0] addr, // Address
  output logic dm, // Write mask
  output logic [7:0] dq, // Write data
  output logic dqs // Write strobe
);
  // Idle bus at time zero
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n, dm, dqs} = 7'h7c;
    ba = 3'h0;
    addr = 14'h0000;
    dq = 8'h00;
    ck = 1'b0;
    forever #32 ck = ~ck;
  end
  // Pins set in the low half and held well past the rise
  task cmd(input logic e, input logic c, input logic [2:0] code, input logic [2:0] b, input logic [13:0] a);
    @(negedge ck);
    @(posedge sys_clk);
    cke <= e;
    cs_n <= c;
    {ras_n, cas_n, we_n} <= code;
    ba <= b;
    addr <= a;
    @(posedge ck);
    repeat (4) @(posedge sys_clk);
    cs_n <= 1'b1;
    {ras_n, cas_n, we_n} <= DDP_CMD_NOP;
    ba <= ~b;
    addr <= ~a;
  endtask
  // One beat per strobe edge, edge three cycles inside the beat
  task wr(input logic [63:0] d, input logic [7:0] m);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      dq <= d[i*8+:8];
      dm <= m[i];
      repeat (3) @(posedge sys_clk);
      dqs <= ~dqs;
      repeat (3) @(posedge sys_clk);
    end
    dq <= ~dq;
  endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for ddp_core
// Assumes: x8 build, controller model drives the link
// Notes: Monitors sample on the falling edge so updates have landed
`timescale 1ns/10ps
module testbench import ddp_pkg::*; ();
  logic sys_clk, sys_rst, mem_rst_n, odt, rd_in_valid, r, pdqs; // Bench controls
  logic ck, cke, cs_n, ras_n, cas_n, we_n, dm, dqs_m; // Controller pins
  logic [2:0] ba; // Bank pins
  logic [13:0] addr; // Address pins
  logic [7:0] dq_m, rd_in_data, dq_out, bank_open, wr_data, opn, mk; // Data and bank state
  logic dq_oe_n, dqs_out, dqs_oe_n, term_on, tdqs_term, dm_enabled, cmd_valid, wr_valid, rd_in_ready;
  logic [1:0] pwr_state, pst; // Power state, seen and expected
  logic [2:0] cmd_code, cmd_bank; // Decoded command
  logic [63:0] d; // Write burst
  logic [31:0] seed = 32'h10; // Random state
  logic [7:0] got_cmd[$], exp_cmd[$], got_wr[$], exp_wr[$], got_rd[$], exp_rd[$];
  int n_fail = 0, check_count = 0, i, j;
  // Wire levels from every driver's enable
  wire logic [7:0] dq_w = dq_oe_n ? dq_m : dq_out;
  wire logic dqs_w = dqs_oe_n ? dqs_m : dqs_out;
  ddp_ctrl_model ddp_ctrl_model_inst (.sys_clk(sys_clk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dm(dm), .dq(dq_m), .dqs(dqs_m));
  ddp_core #(.DQ_W(8), .FIFO_DEPTH(16)) ddp_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .ck(ck),
    .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .odt(odt),
    .mem_rst_n(mem_rst_n), .dm(dm), .dq_in(dq_w), .dqs_in(dqs_w), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
    .dqs_out(dqs_out), .dqs_oe_n(dqs_oe_n), .term_on(term_on), .tdqs_term(tdqs_term),
    .dm_enabled(dm_enabled), .pwr_state(pwr_state), .bank_open(bank_open), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_bank(cmd_bank), .wr_valid(wr_valid), .wr_data(wr_data),
    .rd_in_valid(rd_in_valid), .rd_in_ready(rd_in_ready), .rd_in_data(rd_in_data));
  // 200 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Collect pulses and read beats
  always @(negedge sys_clk) begin
    if (cmd_valid) got_cmd.push_back({2'b00, cmd_code, cmd_bank});
    if (wr_valid) got_wr.push_back(wr_data);
    if (!dq_oe_n && dqs_out !== pdqs) got_rd.push_back(dq_out);
    pdqs <= dqs_out;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpq(ref logic [7:0] g[$], ref logic [7:0] e[$]);
    chk(16'(g.size()), 16'(e.size()));
    while (g.size() > 0 && e.size() > 0) chk(16'(g.pop_front()), 16'(e.pop_front()));
    g.delete();
    e.delete();
  endtask
  // Reference model of decode, banks and power state
  task issue(input logic e, input logic c, input logic [2:0] code, input logic [2:0] b, input logic [13:0] a);
    ddp_ctrl_model_inst.cmd(e, c, code, b, a);
    if (pst == 2'b00 && e && !c && code != DDP_CMD_NOP) begin
      exp_cmd.push_back({2'b00, code, b});
      if (code == DDP_CMD_ACT) opn[b] = 1'b1;
      if (code == DDP_CMD_PRE) opn = a[10] ? 8'h00 : opn & ~(8'h01 << b);
    end
    if (pst == 2'b00 && !e) pst = (!c && code == DDP_CMD_REF && opn == 8'h00) ? 2'b11 : (opn != 0 ? 2'b01 : 2'b10);
    else if (e) pst = 2'b00;
    repeat (6) @(posedge sys_clk);
    chk({pwr_state, bank_open}, {pst, opn});
    cmpq(got_cmd, exp_cmd);
  endtask
  task final_report();
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cut a hang short
  initial begin
    #300000;
    n_fail++;
    final_report();
  end
  initial begin
    {sys_rst, mem_rst_n, odt, rd_in_valid} = 4'hc;
    rd_in_data = 8'h00;
    {opn, pst} = 10'h000;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({dq_oe_n, dm_enabled, cmd_code, rd_in_ready, term_on, pwr_state}, 9'h1f8);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      issue(1, 1, DDP_CMD_ACT, 3'(i), 0);
      issue(1, 0, DDP_CMD_ACT, 3'(i), 0);
    end
    issue(1, 0, DDP_CMD_PRE, 3, 0);
    issue(1, 0, DDP_CMD_PRE, 0, 14'h0400);
    $display("command test done");
    issue(1, 0, DDP_CMD_ACT, 2, 0);
    issue(0, 1, DDP_CMD_NOP, 0, 0);
    issue(0, 0, DDP_CMD_ACT, 5, 0);
    issue(1, 1, DDP_CMD_NOP, 0, 0);
    issue(1, 0, DDP_CMD_PRE, 2, 0);
    issue(0, 1, DDP_CMD_NOP, 0, 0);
    issue(1, 1, DDP_CMD_NOP, 0, 0);
    odt <= 1'b1;
    issue(1, 1, DDP_CMD_NOP, 0, 0);
    chk(term_on, 1);
    issue(0, 0, DDP_CMD_REF, 0, 0);
    chk(term_on, 0);
    issue(1, 1, DDP_CMD_NOP, 0, 0);
    $display("power test done");
    issue(1, 0, DDP_CMD_MRS, DDP_MR1_SEL, 0);
    chk(term_on, 0);
    issue(1, 0, DDP_CMD_MRS, DDP_MR1_SEL, 14'h0804);
    // Termination only follows the control at the next link clock rise
    @(posedge ck);
    repeat (6) @(posedge sys_clk);
    chk({term_on, tdqs_term, dm_enabled}, 3'b110);
    odt <= 1'b0;
    issue(1, 0, DDP_CMD_MRS, DDP_MR1_SEL, 14'h0004);
    chk({term_on, tdqs_term, dm_enabled}, 3'b001);
    $display("termination test done");
    issue(1, 0, DDP_CMD_ACT, 1, 0);
    for (i = 0; i < 2; i++) begin
      d = {rnd(), rnd()};
      mk = 8'(rnd());
      issue(1, 0, DDP_CMD_WR, 1, 0);
      ddp_ctrl_model_inst.wr(d, mk);
      repeat (8) @(posedge sys_clk);
      for (j = 0; j < 8; j++) if (!mk[j]) exp_wr.push_back(d[j*8+:8]);
      cmpq(got_wr, exp_wr);
    end
    $display("write test done");
    rd_in_valid <= 1'b1;
    rd_in_data <= 8'(rnd());
    for (i = 0; i < 20; i++) begin
      @(negedge sys_clk) r = rd_in_ready;
      @(posedge sys_clk);
      if (r) begin
        exp_rd.push_back(rd_in_data);
        rd_in_data <= 8'(rnd());
      end
    end
    rd_in_valid <= 1'b0;
    chk({rd_in_ready, 5'(exp_rd.size())}, 6'h10);
    issue(1, 0, DDP_CMD_RD, 1, 0);
    repeat (50) @(posedge sys_clk);
    issue(1, 0, DDP_CMD_RD, 1, 0);
    repeat (50) @(posedge sys_clk);
    cmpq(got_rd, exp_rd);
    chk({rd_in_ready, dq_oe_n}, 2'b11);
    $display("read test done");
    mem_rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    mem_rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk({pwr_state, bank_open}, 0);
    $display("device reset test done");
    final_report();
  end
endmodule
